/* pll_sleep_and_clock_supervision_test.sv */
// self-checking bench for pscs_top over ahb-lite
// assumes the design and pscs_chk are compiled first
// supply watchdog and bandgap are never touched here
`timescale 1ns/10ps
module pll_sleep_and_clock_supervision_test;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, ctl, rd_v;
  logic [1:0] htrans, master_clock_mux;
  logic [2:0] hsize;
  logic [6:0] pll_ndiv, pll_k2div;
  logic pll_vco_sel, pll_in_sel, pll_power_down_req, pll_sleep_async;
  logic pll_k2_clk_level, pll_old_clk_alive, pll_new_clk_alive, pll_lock;
  logic osc_in_level, low_power_ref_level, osc_seen_good;
  logic oscillator_supervisor_en, lock_detect_en;
  int fails, compares;
  assign hready = hreadyout;
  pscs_top uut (.*);
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // ----
  // tasks
  // ----
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_v = hrdata;
  endtask : xfer
  task automatic rc(input string n, input logic [7:0] a,
                    input logic [31:0] m, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(n, e, rd_v & m);
  endtask : rc
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // reference edges, with or without supervised input edges in step with them
  task automatic ref_run(input logic with_osc);
    repeat (80) begin
      @(posedge hclk);
      low_power_ref_level <= ~low_power_ref_level;
      osc_in_level <= with_osc ? ~osc_in_level : osc_in_level;
      @(posedge hclk);
    end
  endtask : ref_run
  initial begin
    #50000;
    fails++;
    report_and_stop();
  end
  // ----
  // tests
  // ----
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pll_k2_clk_level = 1'b0;
    pll_old_clk_alive = 1'b1;
    pll_new_clk_alive = 1'b1;
    pll_lock = 1'b0;
    osc_in_level = 1'b0;
    low_power_ref_level = 1'b0;
    osc_seen_good = 1'b0;
    fails = 0;
    compares = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc("pll ctl", 8'h00, 32'hFFFFFFFF, 32'h0);
    rc("status", 8'h04, 32'h3F, 32'h7);
    rc("sys ctl", 8'h08, 32'h3133, 32'h10);
    xfer(8'h20, 1'b1, 32'hFFFFFFFF);
    rc("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    xfer(8'h00, 1'b1, 32'h5);
    cyc(2);
    rc("ndiv ready", 8'h04, 32'h1, 32'h0);
    chk("ndiv early", 32'h0, {25'h0, pll_ndiv});
    xfer(8'h00, 1'b1, 32'h0010_0005);
    cyc(4);
    rc("ndiv ready", 8'h04, 32'h1, 32'h1);
    chk("ndiv", 32'h5, {25'h0, pll_ndiv});
    xfer(8'h00, 1'b1, 32'h5);
    cyc(2);
    rc("same ready", 8'h04, 32'h1, 32'h1);
    pll_new_clk_alive <= 1'b0;
    xfer(8'h00, 1'b1, 32'h0001_0005);
    cyc(2);
    rc("vco ready", 8'h04, 32'h2, 32'h0);
    xfer(8'h00, 1'b1, 32'h0021_0005);
    cyc(8);
    rc("vco ready", 8'h04, 32'h2, 32'h0);
    chk("vco held", 32'h0, {31'h0, pll_vco_sel});
    pll_new_clk_alive <= 1'b1;
    cyc(8);
    rc("vco ready", 8'h04, 32'h2, 32'h2);
    chk("vco sel", 32'h1, {31'h0, pll_vco_sel});
    xfer(8'h00, 1'b1, 32'h0003_0005);
    cyc(2);
    ctl = 32'h0043_0005;
    xfer(8'h00, 1'b1, ctl);
    cyc(8);
    rc("in ready", 8'h04, 32'h4, 32'h4);
    chk("in sel", 32'h1, {31'h0, pll_in_sel});
    ctl = ctl | 32'h0100_0000;
    xfer(8'h00, 1'b1, ctl);
    cyc(10);
    rc("going", 8'h04, 32'h8, 32'h0);
    chk("pwd req", 32'h1, {31'h0, pll_power_down_req});
    repeat (6) begin
      @(posedge hclk);
      pll_k2_clk_level <= ~pll_k2_clk_level;
      @(posedge hclk);
    end
    cyc(4);
    rc("asleep", 8'h04, 32'hF, 32'hF);
    chk("sleep", 32'h1, {31'h0, pll_sleep_async});
    ctl = (ctl & 32'hFFFF_8080) | 32'h0000_0309;
    xfer(8'h00, 1'b1, ctl);
    cyc(2);
    chk("ndiv asleep", 32'h9, {25'h0, pll_ndiv});
    chk("k2 asleep", 32'h3, {25'h0, pll_k2div});
    rc("ready asleep", 8'h04, 32'h7, 32'h7);
    xfer(8'h00, 1'b1, ctl & 32'hFEFF_FFFF);
    @(negedge hclk);
    chk("wake", 32'h0, {31'h0, pll_sleep_async});
    @(posedge hclk);
    rc("awake", 8'h04, 32'h8, 32'h0);
    xfer(8'h08, 1'b1, 32'h32);
    xfer(8'h10, 1'b1, 32'h1);
    cyc(3);
    chk("mux", 32'h2, {30'h0, master_clock_mux});
    chk("enables", 32'h1,
        {30'h0, lock_detect_en, oscillator_supervisor_en});
    ref_run(1'b0);
    rc("no seen", 8'h08, 32'h3100, 32'h2000);
    ref_run(1'b1);
    osc_seen_good <= 1'b1;
    ref_run(1'b1);
    rc("osc fine", 8'h08, 32'h3100, 32'h2000);
    ref_run(1'b0);
    rc("emergency", 8'h08, 32'h3100, 32'h3100);
    chk("mux", 32'h3, {30'h0, master_clock_mux});
    ref_run(1'b1);
    xfer(8'h0C, 1'b1, 32'h100);
    cyc(3);
    rc("cleared", 8'h08, 32'h3100, 32'h2000);
    chk("mux", 32'h2, {30'h0, master_clock_mux});
    pll_lock <= 1'b1;
    cyc(4);
    rc("seen lock", 8'h04, 32'h30, 32'h30);
    xfer(8'h10, 1'b1, 32'h3);
    rc("lock det", 8'h10, 32'h3, 32'h3);
    chk("lock en", 32'h1, {31'h0, lock_detect_en});
    xfer(8'h10, 1'b1, 32'h2);
    ref_run(1'b0);
    rc("wdt off", 8'h08, 32'h3100, 32'h2000);
    chk("wdt en", 32'h0, {31'h0, oscillator_supervisor_en});
    report_and_stop();
  end
endmodule : pll_sleep_and_clock_supervision_test
bind pscs_top pscs_chk chk (.*);

/* pscs_chk.sv */
// assertion checker for the pscs_top ports
// assumes it is bound to pscs_top, port names matching
`timescale 1ns/10ps
module pscs_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [6:0] pll_ndiv,
  input wire logic pll_vco_sel,
  input wire logic pll_in_sel,
  input wire logic pll_power_down_req,
  input wire logic pll_sleep_async,
  input wire logic pll_k2_clk_level,
  input wire logic pll_old_clk_alive,
  input wire logic pll_new_clk_alive,
  input wire logic osc_seen_good,
  input wire logic [1:0] master_clock_mux,
  input wire logic oscillator_supervisor_en
);
  // ----
  // write tracking
  // ----
  // edges since a write data phase; saturates so idle spans stay 7
  logic wr_pend;
  logic [2:0] quiet;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      quiet <= 3'h7;
    end else begin
      wr_pend <= hsel & hready & htrans[1] & hwrite;
      if (wr_pend) begin
        quiet <= 3'h0;
      end else if (quiet != 3'h7) begin
        quiet <= quiet + 3'h1;
      end
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ----
  // properties
  // ----
  a_ndiv_after_write:
    assert property ($changed(pll_ndiv) |-> quiet < 3'h6)
    else $error("ndiv moved without a write");
  a_vco_both_alive:
    assert property ($changed(pll_vco_sel) && !$past(pll_power_down_req)
      |-> $past(pll_old_clk_alive, 2) && $past(pll_new_clk_alive, 2))
    else $error("vco mux switched without both clocks");
  a_insel_alive:
    assert property ($rose(pll_in_sel) |-> $past(pll_new_clk_alive, 2))
    else $error("input mux switched without new clock");
  a_asleep_has_req:
    assert property (pll_sleep_async |-> pll_power_down_req)
    else $error("asleep without request");
  a_wake_at_once:
    assert property ($fell(pll_power_down_req) && $past(pll_sleep_async)
      |-> !pll_sleep_async)
    else $error("wakeup delayed");
  a_sleep_on_k2:
    assert property ($rose(pll_sleep_async) |-> $past(pll_power_down_req, 3)
      && ($past(pll_k2_clk_level, 2) || $past(pll_k2_clk_level, 3)
      || $past(pll_k2_clk_level, 4) || $past(pll_k2_clk_level, 5)))
    else $error("sleep entered without k2 edge");
  a_em_needs_seen:
    assert property ($changed(master_clock_mux) && quiet == 3'h7
      |-> oscillator_supervisor_en && $past(osc_seen_good, 2))
    else $error("emergency switch not allowed");
  a_pwd_by_write:
    assert property ($changed(pll_power_down_req) |-> quiet == 3'h0)
    else $error("power-down bit moved alone");
  c_sleep: cover property ($rose(pll_sleep_async));
  c_emergency: cover property ($changed(master_clock_mux) && quiet == 3'h7);
  c_vco: cover property ($rose(pll_vco_sel));
endmodule : pscs_chk

/* pscs_pkg.sv */
// package for the pll sleep and clock supervision block
// assumes a 32-bit ahb-lite register bus on hclk
package pscs_pkg;
  // register byte offsets
  localparam logic [7:0] PSCS_PLL_CONTROL_ONE = 8'h00;
  localparam logic [7:0] PSCS_PLL_STATUS = 8'h04;
  localparam logic [7:0] PSCS_SYSTEM_CLOCK_CONTROL = 8'h08;
  localparam logic [7:0] PSCS_CLOCK_STATUS_CLEAR = 8'h0C;
  localparam logic [7:0] PSCS_SUPERVISOR_CONTROL = 8'h10;
  // pll_control_one fields
  localparam int PSCS_NDIV_LSB = 0;
  localparam int PSCS_NDIV_W = 7;
  localparam int PSCS_K2_LSB = 8;
  localparam int PSCS_K2_W = 7;
  localparam int PSCS_VCOSEL_BIT = 16;
  localparam int PSCS_INSEL_BIT = 17;
  localparam int PSCS_NACK_BIT = 20;
  localparam int PSCS_VACK_BIT = 21;
  localparam int PSCS_IACK_BIT = 22;
  localparam int PSCS_PWD_BIT = 24;
  // pll_status fields
  localparam int PSCS_NRDY_BIT = 0;
  localparam int PSCS_VRDY_BIT = 1;
  localparam int PSCS_IRDY_BIT = 2;
  localparam int PSCS_ASLEEP_BIT = 3;
  localparam int PSCS_SEEN_BIT = 4;
  localparam int PSCS_LOCK_BIT = 5;
  // system_clock_control fields
  localparam int PSCS_NORMAL_CLOCK_SELECT_LSB = 0;
  localparam int PSCS_EMSEL_LSB = 4;
  localparam int PSCS_SEL_W = 2;
  localparam int PSCS_EMFLAG_BIT = 8;
  localparam int PSCS_MUX_LSB = 12;
  // supervisor_control fields
  localparam int PSCS_OSCILLATOR_SUPERVISOR_EN_BIT = 0;
  localparam int PSCS_LOCKDET_EN_BIT = 1;
  // reset values
  localparam logic [31:0] PSCS_PLL_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] PSCS_EMSEL_RST = 2'h1;
  // oscillator watchdog: low-power reference clocks counted per window
  // of supervised input; reaching the limit means input below 300 kHz
  localparam int PSCS_OSC_FAIL_KHZ = 300;
  localparam int PSCS_REF_KHZ = 10000;
  localparam int PSCS_REF_PER_FAIL = PSCS_REF_KHZ / PSCS_OSC_FAIL_KHZ;
  localparam logic [7:0] PSCS_REF_LIMIT = 8'(PSCS_REF_PER_FAIL);
  typedef enum logic [1:0] {PSCS_AWAKE, PSCS_GOING, PSCS_ASLEEP} pscs_sleep_t;
endpackage : pscs_pkg

/* pscs_top.sv */
// pll sleep, divider handshakes and oscillator watchdog emergency switch
// assumes single ahb-lite master; pll-side pins come from other clocks
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module pscs_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pll analog side
  output logic [6:0] pll_ndiv,
  output logic [6:0] pll_k2div,
  output logic pll_vco_sel,
  output logic pll_in_sel,
  output logic pll_power_down_req,
  output logic pll_sleep_async,
  input wire logic pll_k2_clk_level,
  input wire logic pll_old_clk_alive,
  input wire logic pll_new_clk_alive,
  input wire logic pll_lock,
  input wire logic osc_in_level,
  input wire logic low_power_ref_level,
  input wire logic osc_seen_good,
  output logic [1:0] master_clock_mux,
  output logic oscillator_supervisor_en,
  output logic lock_detect_en
);
  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_pend;
  logic [7:0] rd_addr;
  logic [31:0] ctrl;
  logic [1:0] clk_sel;
  logic [1:0] em_sel;
  logic em_flag;
  logic [1:0] sup_en;
  logic [2:0] rdy;
  logic [2:0] pend;
  pscs_pkg::pscs_sleep_t sleep_st;
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] sync3;
  logic [31:0] next_ctrl;
  logic wr_ctrl;
  logic status_clr;
  logic emergency;
  wire logic take = hsel && hready && htrans[1];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
    end else begin
      wr_pend <= take && hwrite;
      rd_pend <= take && !hwrite;
      wr_addr <= haddr[7:0];
      rd_addr <= haddr[7:0];
    end
  end

  assign wr_ctrl = wr_pend && wr_addr == pscs_pkg::PSCS_PLL_CONTROL_ONE;
  assign status_clr = wr_pend &&
    wr_addr == pscs_pkg::PSCS_CLOCK_STATUS_CLEAR &&
    hwdata[pscs_pkg::PSCS_EMFLAG_BIT];
  assign next_ctrl = wr_ctrl ? hwdata : ctrl;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= pscs_pkg::PSCS_PLL_CTRL_RST;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sel <= 2'h0;
      em_sel <= pscs_pkg::PSCS_EMSEL_RST;
      sup_en <= 2'h0;
    end else if (wr_pend) begin
      if (wr_addr == pscs_pkg::PSCS_SYSTEM_CLOCK_CONTROL) begin
        clk_sel <= hwdata[pscs_pkg::PSCS_NORMAL_CLOCK_SELECT_LSB +: pscs_pkg::PSCS_SEL_W];
        em_sel <= hwdata[pscs_pkg::PSCS_EMSEL_LSB +: pscs_pkg::PSCS_SEL_W];
      end else if (wr_addr == pscs_pkg::PSCS_SUPERVISOR_CONTROL) begin
        sup_en <= hwdata[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers: k2 clock, alive flags, lock, osc, reference
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      sync3 <= 6'h00;
    end else begin
      sync1 <= {low_power_ref_level, osc_in_level, pll_lock,
                pll_new_clk_alive, pll_old_clk_alive, pll_k2_clk_level};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  wire logic k2_edge = sync2[0] && !sync3[0];
  wire logic both_alive = sync2[1] && sync2[2];
  wire logic osc_edge = sync2[4] && !sync3[4];
  wire logic ref_edge = sync2[5] && !sync3[5];

  // ---------------------------------------------------------------
  // handshakes: n divider, vco mux, input mux
  // ---------------------------------------------------------------
  logic [2:0] changed;
  logic [2:0] ackbit;
  assign changed[0] = wr_ctrl && hwdata[pscs_pkg::PSCS_NDIV_LSB +:
    pscs_pkg::PSCS_NDIV_W] != ctrl[pscs_pkg::PSCS_NDIV_LSB +:
    pscs_pkg::PSCS_NDIV_W];
  assign changed[1] = wr_ctrl && hwdata[pscs_pkg::PSCS_VCOSEL_BIT] !=
    ctrl[pscs_pkg::PSCS_VCOSEL_BIT];
  assign changed[2] = wr_ctrl && hwdata[pscs_pkg::PSCS_INSEL_BIT] !=
    ctrl[pscs_pkg::PSCS_INSEL_BIT];
  assign ackbit = {ctrl[pscs_pkg::PSCS_IACK_BIT],
    ctrl[pscs_pkg::PSCS_VACK_BIT], ctrl[pscs_pkg::PSCS_NACK_BIT]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_hs
      // asleep: config is preset, so ready needs no handshake
      wire logic asleep = sleep_st == pscs_pkg::PSCS_ASLEEP;
      // mux channels (1, 2) complete only with both clocks running
      wire logic can_go = (gi == 0) || both_alive;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rdy[gi] <= 1'b1;
          pend[gi] <= 1'b0;
        end else if (changed[gi] && !asleep) begin
          rdy[gi] <= 1'b0;
          pend[gi] <= 1'b1;
        end else if (asleep) begin
          rdy[gi] <= 1'b1;
          pend[gi] <= 1'b0;
        end else if (pend[gi] && ackbit[gi] && can_go) begin
          rdy[gi] <= 1'b1;
          pend[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ndiv, vco and input mux values follow only on handshake completion, or at once asleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_ndiv <= 7'h00;
      pll_vco_sel <= 1'b0;
      pll_in_sel <= 1'b0;
      pll_k2div <= 7'h00;
    end else begin
      if (sleep_st == pscs_pkg::PSCS_ASLEEP ||
          (pend[0] && ackbit[0])) begin
        pll_ndiv <= ctrl[pscs_pkg::PSCS_NDIV_LSB +: pscs_pkg::PSCS_NDIV_W];
      end
      if (sleep_st == pscs_pkg::PSCS_ASLEEP ||
          (pend[1] && ackbit[1] && both_alive)) begin
        pll_vco_sel <= ctrl[pscs_pkg::PSCS_VCOSEL_BIT];
      end
      if (sleep_st == pscs_pkg::PSCS_ASLEEP ||
          (pend[2] && ackbit[2] && both_alive)) begin
        pll_in_sel <= ctrl[pscs_pkg::PSCS_INSEL_BIT];
      end
      // k2 has no handshake; frozen only while shutdown is in flight
      if (sleep_st != pscs_pkg::PSCS_GOING) begin
        pll_k2div <= ctrl[pscs_pkg::PSCS_K2_LSB +: pscs_pkg::PSCS_K2_W];
      end
    end
  end

  // ---------------------------------------------------------------
  // pll sleep
  // ---------------------------------------------------------------
  wire logic pwd_bit = ctrl[pscs_pkg::PSCS_PWD_BIT];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_st <= pscs_pkg::PSCS_AWAKE;
    end else begin
      case (sleep_st)
        pscs_pkg::PSCS_AWAKE: begin
          if (pwd_bit) begin
            sleep_st <= pscs_pkg::PSCS_GOING;
          end
        end
        pscs_pkg::PSCS_GOING: begin
          if (!pwd_bit) begin
            sleep_st <= pscs_pkg::PSCS_AWAKE;
          end else if (k2_edge) begin
            sleep_st <= pscs_pkg::PSCS_ASLEEP;
          end
        end
        default: begin
          if (!pwd_bit) begin
            sleep_st <= pscs_pkg::PSCS_AWAKE;
          end
        end
      endcase
    end
  end
  assign pll_power_down_req = pwd_bit;
  // wakeup: drop sleep combinationally as soon as the bit clears
  assign pll_sleep_async = pwd_bit &&
    sleep_st == pscs_pkg::PSCS_ASLEEP;

  // ---------------------------------------------------------------
  // oscillator watchdog and emergency mux
  // ---------------------------------------------------------------
  logic [7:0] ref_cnt;
  logic osc_low;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt <= 8'h00;
      osc_low <= 1'b0;
    end else if (osc_edge) begin
      ref_cnt <= 8'h00;
      osc_low <= 1'b0;
    end else if (ref_edge && ref_cnt != pscs_pkg::PSCS_REF_LIMIT) begin
      ref_cnt <= ref_cnt + 8'h01;
    end else if (ref_cnt == pscs_pkg::PSCS_REF_LIMIT) begin
      osc_low <= 1'b1;
    end
  end
  logic osc_seen_good_s1;
  logic osc_seen_good_s;
  assign emergency = osc_low && sup_en[pscs_pkg::PSCS_OSCILLATOR_SUPERVISOR_EN_BIT] &&
    osc_seen_good_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_seen_good_s1 <= 1'b0;
      osc_seen_good_s <= 1'b0;
    end else begin
      osc_seen_good_s1 <= osc_seen_good;
      osc_seen_good_s <= osc_seen_good_s1;
    end
  end
  // set wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      em_flag <= 1'b0;
    end else if (emergency) begin
      em_flag <= 1'b1;
    end else if (status_clr) begin
      em_flag <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      master_clock_mux <= 2'h0;
    end else begin
      master_clock_mux <= em_flag ? em_sel : clk_sel;
    end
  end
  assign oscillator_supervisor_en = sup_en[pscs_pkg::PSCS_OSCILLATOR_SUPERVISOR_EN_BIT];
  assign lock_detect_en = sup_en[pscs_pkg::PSCS_LOCKDET_EN_BIT];

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      if (haddr[7:0] == pscs_pkg::PSCS_PLL_CONTROL_ONE) begin
        hrdata <= next_ctrl;
      end else if (haddr[7:0] == pscs_pkg::PSCS_PLL_STATUS) begin
        hrdata <= {26'h0, sync2[3], osc_seen_good_s,
          sleep_st == pscs_pkg::PSCS_ASLEEP, rdy};
      end else if (haddr[7:0] == pscs_pkg::PSCS_SYSTEM_CLOCK_CONTROL) begin
        hrdata <= {18'h0, master_clock_mux, 3'h0, em_flag, 2'h0, em_sel,
          2'h0, clk_sel};
      end else if (haddr[7:0] == pscs_pkg::PSCS_SUPERVISOR_CONTROL) begin
        hrdata <= {30'h0, sup_en};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end
  wire logic unused_ok = rd_pend ^ (|rd_addr) ^ (|hsize);
endmodule : pscs_top
